// ---- hdl/qctg_pkg.sv ----
// constants and types shared by the quarter-cycle timing generator
package qctg_pkg;
  // quarter-cycle phase codes, one clock per quarter
  typedef enum logic [1:0] {
    QCTG_Q1 = 2'b00,                       // first quarter, instruction latch open
    QCTG_Q2 = 2'b01,                       // second quarter, end of input phase
    QCTG_Q3 = 2'b10,                       // third quarter, address latch open
    QCTG_Q4 = 2'b11                        // fourth quarter, master clock high
  } qctg_quarter_t;

  // bus widths
  localparam int unsigned INSTR_W = 16;    // instruction word
  localparam int unsigned ADDR_W  = 13;    // program address
  localparam int unsigned IO_W    = 8;     // i/o bus

  // instruction fields
  localparam int unsigned OPC_MSB      = 15;  // opcode field top bit
  localparam int unsigned OPC_LSB      = 13;  // opcode field bottom bit
  localparam int unsigned SRC_BANK_BIT = 12;  // source bank: 1 = right bank
  localparam int unsigned DST_IO_BIT   = 4;   // destination is the i/o bus
  localparam int unsigned DST_BANK_BIT = 3;   // destination bank: 1 = right bank
  localparam int unsigned DST_MSB      = 4;   // destination field top bit
  localparam int unsigned BIT_SEL_MSB  = 7;   // tested bit index top
  localparam int unsigned BIT_SEL_LSB  = 5;   // tested bit index bottom

  // opcodes and destination codes
  localparam logic [2:0] OPC_TEST_BRANCH = 3'h5;  // test_bit_branch
  localparam logic [2:0] OPC_JUMP        = 3'h7;  // absolute jump
  localparam logic [4:0] DST_SELECT      = 5'h07; // destination that raises select strobe

  // address steps
  localparam logic [ADDR_W-1:0] ADDR_STEP = 13'h0001; // sequential step
  localparam logic [ADDR_W-1:0] ADDR_SKIP = 13'h0005; // taken bit-test offset
  localparam logic [ADDR_W-1:0] ADDR_RST  = 13'h0000; // address after reset
endpackage : qctg_pkg

// ---- hdl/qctg_timing_gen.sv ----
// quarter-cycle timing generator: phases, master clock, latches, address, bank enables
`timescale 1ns/1ps

module qctg_timing_gen (
  input  wire logic                         clk,                   // oscillator clock, 4 ns
  input  wire logic                         rst_b,                 // synchronous reset, low
  input  wire logic                         clk_en,                // freezes all state when low
  input  wire logic [qctg_pkg::INSTR_W-1:0] instr_in,              // instruction pins
  input  wire logic                         halt_n,                // halt pin, low halts
  input  wire logic [qctg_pkg::IO_W-1:0]    io_in,                 // i/o bus input level
  output logic      [qctg_pkg::IO_W-1:0]    io_out,                // i/o bus drive value
  output logic                              io_oe,                 // i/o bus drive enable
  output logic      [qctg_pkg::ADDR_W-1:0]  program_address_out,   // program address
  output logic                              master_clk,            // master clock output
  output logic                              select_command_strobe, // select command
  output logic                              write_command_strobe,  // write command
  output logic                              left_bank_enable_n,    // left bank, low active
  output logic                              right_bank_enable_n,   // right bank, low active
  output logic      [3:0]                   quarter_onehot         // phase strobes q1..q4
);

  // quarter counter and its successor
  qctg_pkg::qctg_quarter_t quarter_q;      // current quarter
  qctg_pkg::qctg_quarter_t quarter_d;      // next quarter

  // two-flop synchronisers for pin inputs
  logic [qctg_pkg::INSTR_W-1:0] instr_s1_q;  // first stage, read only by second
  logic [qctg_pkg::INSTR_W-1:0] instr_s2_q;  // synchronised instruction
  logic [qctg_pkg::IO_W-1:0]    io_s1_q;     // first stage
  logic [qctg_pkg::IO_W-1:0]    io_s2_q;     // synchronised i/o input
  logic                         halt_s1_q;   // first stage
  logic                         halt_s2_q;   // synchronised halt

  // internal latches
  logic [qctg_pkg::INSTR_W-1:0] instr_lat_q; // instruction latch
  logic [qctg_pkg::IO_W-1:0]    io_lat_q;    // i/o bus input latch
  logic [qctg_pkg::IO_W-1:0]    alu_lat_q;   // alu input latch
  logic                         halt_cyc_q;  // current cycle is a halt cycle
  logic                         halt_cyc_d;  // halt cycle for next state

  // decode wires
  logic                         in_q1;       // first quarter
  logic                         in_q2;       // second quarter
  logic                         in_q3;       // third quarter
  logic                         in_q4;       // fourth quarter
  logic [3:0]                   onehot_now;  // phase strobes now
  logic                         in_input;    // input phase as seen past the synchroniser
  logic [2:0]                   opcode;      // latched opcode
  logic                         is_jump;     // jump instruction
  logic                         is_test;     // bit-test branch
  logic                         tested_bit;  // bit picked from synchronised i/o input
  logic                         skip_taken;  // bit-test skips ahead
  logic [qctg_pkg::ADDR_W-1:0]  next_addr;   // computed next address
  logic                         sel_req;     // instruction wants select strobe
  logic                         wr_req;      // instruction wants write strobe
  logic                         bank_out_req;// output phase needs a bank change

  // next-value wires for the registered outputs
  logic                         mclk_d;      // master clock next
  logic                         oe_d;        // driver enable next
  logic                         sc_d;        // select strobe next
  logic                         wc_d;        // write strobe next
  logic [3:0]                   onehot_d;    // phase strobes next
  logic                         bank_right_d;// right bank chosen next
  logic                         bank_right_q;// right bank chosen now

  // quarter decode, used for both present and next phase
  function automatic logic [3:0] qctg_decode(input qctg_pkg::qctg_quarter_t q);
    qctg_decode = 4'h0;
    unique case (q)
      qctg_pkg::QCTG_Q1: qctg_decode = 4'h1;
      qctg_pkg::QCTG_Q2: qctg_decode = 4'h2;
      qctg_pkg::QCTG_Q3: qctg_decode = 4'h4;
      qctg_pkg::QCTG_Q4: qctg_decode = 4'h8;
    endcase
  endfunction : qctg_decode

  // counter wraps q4 -> q1 on its own
  assign quarter_d = qctg_pkg::qctg_quarter_t'(quarter_q + 2'h1);
  assign onehot_now = qctg_decode(quarter_q);
  assign in_q1     = onehot_now[0];
  assign in_q2     = onehot_now[1];
  assign in_q3     = onehot_now[2];
  assign in_q4     = onehot_now[3];
  // bus pins land two clocks late, so q3/q4 hold the input-phase levels
  assign in_input  = in_q3 | in_q4;
  assign onehot_d  = qctg_decode(quarter_d);

  // instruction decode from the latched word
  assign opcode     = instr_lat_q[qctg_pkg::OPC_MSB:qctg_pkg::OPC_LSB];
  assign is_jump    = (opcode == qctg_pkg::OPC_JUMP);
  assign is_test    = (opcode == qctg_pkg::OPC_TEST_BRANCH);
  // io_s2_q in q3 carries the bus as it stood in q1, before our drivers turn on;
  // the latched copy would arrive one clock too late for the q3 address update
  assign tested_bit = io_s2_q[instr_lat_q[qctg_pkg::BIT_SEL_MSB:qctg_pkg::BIT_SEL_LSB]];
  // skip only when the source is the right bank
  assign skip_taken = is_test & instr_lat_q[qctg_pkg::SRC_BANK_BIT] & tested_bit;

  // next address waits on latched instruction and the input-phase bus level
  assign next_addr = is_jump    ? instr_lat_q[qctg_pkg::ADDR_W-1:0] :
                     skip_taken ? program_address_out + qctg_pkg::ADDR_SKIP :
                                  program_address_out + qctg_pkg::ADDR_STEP;

  // strobe requests are exclusive by construction
  assign sel_req = (instr_lat_q[qctg_pkg::DST_MSB:0] == qctg_pkg::DST_SELECT);
  assign wr_req  = instr_lat_q[qctg_pkg::DST_IO_BIT] & ~sel_req;
  assign bank_out_req = instr_lat_q[qctg_pkg::DST_IO_BIT];

  // master clock rises entering q4 and falls leaving it
  assign mclk_d = onehot_d[3];
  // drivers only in q3/q4 of a non-halt cycle
  assign oe_d = (onehot_d[2] | onehot_d[3]) & ~halt_cyc_d;
  // strobes only move entering q1 (drop) or q3 (raise)
  assign sc_d = onehot_d[2] ? (sel_req & ~halt_cyc_d) :
                onehot_d[0] ? 1'b0 : select_command_strobe;
  assign wc_d = onehot_d[2] ? (wr_req & ~halt_cyc_d) :
                onehot_d[0] ? 1'b0 : write_command_strobe;

  // halt is sampled at the close of q1 and rules the rest of the cycle
  assign halt_cyc_d = in_q1 ? ~halt_s2_q : halt_cyc_q;

  // bank: follow instruction pins in input phase, change at q3 only if asked
  assign bank_right_d = (onehot_d[0] | onehot_d[1]) ?
                          instr_s2_q[qctg_pkg::SRC_BANK_BIT] :
                        (onehot_d[2] & bank_out_req & ~halt_cyc_d) ?
                          instr_lat_q[qctg_pkg::DST_BANK_BIT] :
                          bank_right_q;

  // pin synchronisers; pins never feed logic directly
  always_ff @(posedge clk) begin
    if (clk_en) begin
      instr_s1_q <= instr_in;
      instr_s2_q <= instr_s1_q;
      io_s1_q    <= io_in;
      io_s2_q    <= io_s1_q;
      halt_s1_q  <= halt_n;
      halt_s2_q  <= halt_s1_q;
    end
  end

  // free-running quarter counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      quarter_q <= qctg_pkg::QCTG_Q1;
    end else if (clk_en) begin
      quarter_q <= quarter_d;
    end
  end

  // instruction latch: transparent in q1, holds from its trailing edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      instr_lat_q <= '0;
    end else if (clk_en && in_q1) begin
      instr_lat_q <= instr_s2_q;
    end
  end

  // i/o and alu input latches: open for the two clocks carrying the input phase
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      io_lat_q  <= '0;
      alu_lat_q <= '0;
    end else if (clk_en && in_input) begin
      io_lat_q  <= io_s2_q;
      alu_lat_q <= io_s2_q;
    end
  end

  // halt flag for the current cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      halt_cyc_q <= 1'b0;
    end else if (clk_en) begin
      halt_cyc_q <= halt_cyc_d;
    end
  end

  // address latch closes at the end of q3; held through q4, q1, q2
  // a halt cycle keeps the address so the same word is refetched
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      program_address_out <= qctg_pkg::ADDR_RST;
    end else if (clk_en && in_q3 && !halt_cyc_q) begin
      program_address_out <= next_addr;
    end
  end

  // registered phase-driven outputs; reset holds the master clock low
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      master_clk            <= 1'b0;
      io_oe                 <= 1'b0;
      select_command_strobe <= 1'b0;
      write_command_strobe  <= 1'b0;
      quarter_onehot        <= 4'h1;
    end else if (clk_en) begin
      master_clk            <= mclk_d;
      io_oe                 <= oe_d;
      select_command_strobe <= sc_d;
      write_command_strobe  <= wc_d;
      quarter_onehot        <= onehot_d;
    end
  end

  // output data: latched immediate, loaded as drivers turn on
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      io_out <= '0;
    end else if (clk_en && in_q2) begin
      io_out <= instr_lat_q[qctg_pkg::IO_W-1:0];
    end
  end

  // complementary bank enables from one decision
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bank_right_q        <= 1'b0;
      left_bank_enable_n  <= 1'b0;
      right_bank_enable_n <= 1'b1;
    end else if (clk_en) begin
      bank_right_q        <= bank_right_d;
      left_bank_enable_n  <= bank_right_d;
      right_bank_enable_n <= ~bank_right_d;
    end
  end

  // latch copies are kept for the alu path, which lies outside this block
  logic unused_q4;                                                      // spare latch sink
  assign unused_q4 = ^alu_lat_q & ^io_lat_q;

endmodule : qctg_timing_gen

// ---- tb/qctg_props.sv ----
// assertion checker for the quarter-cycle timing generator
`timescale 1ns/1ps
module qctg_props (
  input wire logic                        clk,                   // clock
  input wire logic                        rst_b,                 // reset, low
  input wire logic                        clk_en,                // state enable
  input wire logic                        io_oe,                 // bus drive
  input wire logic [qctg_pkg::ADDR_W-1:0] program_address_out,   // address
  input wire logic                        master_clk,            // master clock
  input wire logic                        select_command_strobe, // select
  input wire logic                        write_command_strobe,  // write
  input wire logic                        left_bank_enable_n,    // left bank
  input wire logic                        right_bank_enable_n,   // right bank
  input wire logic [3:0]                  quarter_onehot         // phases
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // phases rotate one step per enabled clock
  property p_quarter_seq;
    clk_en |=> quarter_onehot == {$past(quarter_onehot[2:0]), $past(quarter_onehot[3])};
  endproperty
  a_quarter_seq: assert property (p_quarter_seq)
    else $error("phase order broken");
  property p_mclk_q4;
    master_clk == quarter_onehot[3];
  endproperty
  a_mclk_q4: assert property (p_mclk_q4)
    else $error("master clock off q4");
  // the reset edge itself may clear the address
  property p_addr_hold;
    $changed(program_address_out) |-> quarter_onehot[3] || !$past(rst_b);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved early");
  property p_io_drive;
    io_oe |-> quarter_onehot[2] || quarter_onehot[3];
  endproperty
  a_io_drive: assert property (p_io_drive)
    else $error("bus driven in q1/q2");
  property p_io_span;
    $rose(io_oe) |-> quarter_onehot[2] ##1 io_oe ##1 !io_oe;
  endproperty
  a_io_span: assert property (p_io_span)
    else $error("bus drive span wrong");
  property p_strobe_excl;
    !(select_command_strobe && write_command_strobe);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("both strobes high");
  property p_strobe_edge;
    $changed(select_command_strobe) || $changed(write_command_strobe)
      |-> quarter_onehot[0] || quarter_onehot[2] || !$past(rst_b);
  endproperty
  a_strobe_edge: assert property (p_strobe_edge)
    else $error("strobe moved off q1/q3");
  property p_bank_pair;
    left_bank_enable_n != right_bank_enable_n;
  endproperty
  a_bank_pair: assert property (p_bank_pair)
    else $error("bank enables equal");
  property p_bank_out;
    $changed(right_bank_enable_n) |-> !quarter_onehot[3] || !$past(rst_b);
  endproperty
  a_bank_out: assert property (p_bank_out)
    else $error("bank moved entering q4");
endmodule : qctg_props

bind qctg_timing_gen qctg_props i_props (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
  .io_oe(io_oe), .program_address_out(program_address_out), .master_clk(master_clk),
  .select_command_strobe(select_command_strobe), .write_command_strobe(write_command_strobe),
  .left_bank_enable_n(left_bank_enable_n), .right_bank_enable_n(right_bank_enable_n),
  .quarter_onehot(quarter_onehot));

// ---- tb/qctg_far_side.sv ----
// program store and bank-selected port model facing the generator
`timescale 1ns/1ps
module qctg_far_side (
  input  wire logic [qctg_pkg::ADDR_W-1:0]  program_address_out, // fetch address
  input  wire logic                         io_oe,               // device on bus
  input  wire logic [qctg_pkg::IO_W-1:0]    io_out,              // device bus data
  input  wire logic                         left_bank_enable_n,  // left port select
  input  wire logic                         right_bank_enable_n, // right port select
  input  wire logic [qctg_pkg::IO_W-1:0]    port_val,            // port content
  output logic      [qctg_pkg::INSTR_W-1:0] instr_in,            // fetched word
  output logic      [qctg_pkg::IO_W-1:0]    io_in                // resolved bus
);
  logic [qctg_pkg::INSTR_W-1:0] rom [16]; // small store, address wraps
  // word follows the address only, so it holds through the input phase
  assign instr_in = rom[program_address_out[3:0]];
  // device data while it drives; port while selected and the device is off; pull-up otherwise
  assign io_in = io_oe ? io_out
               : (!(left_bank_enable_n && right_bank_enable_n) ? port_val : 8'hff);
endmodule : qctg_far_side

// ---- tb/testbench.sv ----
// self-checking bench for the quarter-cycle timing generator
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [15:0] word; // instruction filling the store
    logic [7:0]  port; // port content
    logic        jump; // step holds a jump target
    logic [12:0] step; // address increment or target
    logic        sel;  // select strobe in q3
    logic        wr;   // write strobe in q3
  } qctg_row_t;
  // uniform store contents keep the fetch pipeline depth out of the expectations
  localparam qctg_row_t ROWS [7] = '{
    '{16'h0000, 8'h00, 1'b0, 13'h0001, 1'b0, 1'b0},
    '{16'h0007, 8'h00, 1'b0, 13'h0001, 1'b1, 1'b0},
    '{16'h0018, 8'h00, 1'b0, 13'h0001, 1'b0, 1'b1},
    '{16'hb060, 8'h08, 1'b0, 13'h0005, 1'b0, 1'b0},
    '{16'hb060, 8'hf7, 1'b0, 13'h0001, 1'b0, 1'b0},
    '{16'ha060, 8'h08, 1'b0, 13'h0001, 1'b0, 1'b0},
    '{16'hea48, 8'h00, 1'b1, 13'h0a48, 1'b0, 1'b0}};
  logic        clk, rst_b, clk_en, halt_n;         // driven inputs
  logic [7:0]  port_val;                           // port content
  logic [15:0] instr_in;                           // from store
  logic [7:0]  io_in, io_out;                      // bus
  logic [12:0] program_address_out, a0;            // address, snapshot
  logic        io_oe, master_clk, sel_s, wr_s, lb_n, rb_n; // outputs
  logic [3:0]  quarter_onehot;                     // phases
  int          error_cnt, checked, cycles, i, k;  // bookkeeping
  qctg_timing_gen i_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .instr_in(instr_in),
    .halt_n(halt_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .program_address_out(program_address_out), .master_clk(master_clk),
    .select_command_strobe(sel_s), .write_command_strobe(wr_s), .left_bank_enable_n(lb_n),
    .right_bank_enable_n(rb_n), .quarter_onehot(quarter_onehot));
  qctg_far_side i_far (.program_address_out(program_address_out), .io_oe(io_oe),
    .io_out(io_out), .left_bank_enable_n(lb_n), .right_bank_enable_n(rb_n),
    .port_val(port_val), .instr_in(instr_in), .io_in(io_in));
  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // sample at the falling edge, after the rising edge updates land
  task automatic wait_q(input int b);
    do @(negedge clk); while (quarter_onehot !== 4'(1 << b));
  endtask : wait_q
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // hang guard, well above the roughly 200 cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    rst_b = 1'b0; clk_en = 1'b1; halt_n = 1'b1; port_val = 8'h00;
    for (k = 0; k < 16; k++) i_far.rom[k] = 16'h0000;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 7; i++) begin
      @(posedge clk) port_val <= ROWS[i].port;
      for (k = 0; k < 16; k++) i_far.rom[k] <= ROWS[i].word;
      repeat (16) @(posedge clk);
      wait_q(3);
      a0 = program_address_out;
      wait_q(1);
      chk({lb_n, rb_n}, {ROWS[i].word[12], ~ROWS[i].word[12]});
      wait_q(2);
      chk({io_oe, sel_s, wr_s}, {1'b1, ROWS[i].sel, ROWS[i].wr});
      chk(io_out, ROWS[i].word[7:0]);
      // an i/o destination moves the bank to its destination bit at q3
      chk({1'b0, rb_n},
          {1'b0, ~(ROWS[i].word[4] ? ROWS[i].word[3] : ROWS[i].word[12])});
      wait_q(3);
      chk({master_clk, program_address_out},
          {1'b1, ROWS[i].jump ? ROWS[i].step : a0 + ROWS[i].step});
    end
    // halt cycles: bus off, strobes low, address frozen, master clock alive
    @(posedge clk) halt_n <= 1'b0;
    for (k = 0; k < 16; k++) i_far.rom[k] <= 16'h0007;
    repeat (12) @(posedge clk);
    wait_q(3);
    a0 = program_address_out;
    wait_q(2);
    chk({io_oe, sel_s, wr_s}, 3'h0);
    wait_q(3);
    chk({master_clk, program_address_out}, {1'b1, a0});
    @(posedge clk) halt_n <= 1'b1;
    // frozen clock enable stops the phase counter in q2
    wait_q(0);
    @(posedge clk) clk_en <= 1'b0;
    repeat (3) @(negedge clk);
    chk(quarter_onehot, 4'h2);
    @(posedge clk) clk_en <= 1'b1;
    // reset in mid-run; the release edge itself still sees reset, q2 follows one edge later
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(negedge clk);
    chk({quarter_onehot, io_oe, master_clk, program_address_out},
        {4'h1, 1'b0, 1'b0, qctg_pkg::ADDR_RST});
    @(posedge clk) rst_b <= 1'b1;
    @(negedge clk);
    chk(quarter_onehot, 4'h1);
    @(negedge clk);
    chk(quarter_onehot, 4'h2);
    final_report();
  end
endmodule : testbench
